// file: design/dtpc_pkg.sv
// Purpose: shared constants and helpers of the dual 8-bit timer block
// Assumes: byte-wide register port, one system clock
package dtpc_pkg;
  // register map
  localparam logic [7:0] ADDR_T0_CTRL = 8'hB0;
  localparam logic [7:0] ADDR_T0_DATA = 8'hB1;
  localparam logic [7:0] ADDR_T0_CNT  = 8'hB2;
  localparam logic [7:0] ADDR_T1_CTRL = 8'hB3;
  localparam logic [7:0] ADDR_T1_DATA = 8'hB4;
  localparam logic [7:0] ADDR_T1_CNT  = 8'hB5;
  localparam logic [7:0] ADDR_IRQ_REQ = 8'hBA;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'hBB;
  // control fields
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 5;
  localparam int CLR_BIT = 4;
  localparam int CS_HI   = 3;
  // reset values and counter limits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hFF;
  localparam logic [3:0] IRQ_RST  = 4'h0;
  // request field sits in bits 7..4; index within the field
  localparam int IRQ_LSB      = 4;
  localparam int IRQ_T0_MATCH = 3;
  localparam int IRQ_T0_OVF   = 2;
  localparam int IRQ_T1_MATCH = 1;
  localparam int IRQ_T1_OVF   = 0;
  // clock select codes
  localparam logic [3:0] CS_STOP      = 4'h0;
  localparam logic [3:0] CS_EXT_RISE  = 4'h5;
  localparam logic [3:0] CS_EXT_FALL  = 4'h6;
  localparam logic [3:0] CS_DIV_FIRST = 4'h8;
  // prescaler width and log2 divisor tables, code 000 in the low nibble
  localparam int PSC_W = 11;
  localparam logic [31:0] U0_SHIFT = 32'hB9754321;
  localparam logic [31:0] U1_SHIFT = 32'hA8643210;

  typedef enum logic [1:0] {
    DTPC_INTERVAL = 2'b00,
    DTPC_PWM      = 2'b01,
    DTPC_CAPTURE  = 2'b10
  } dtpc_mode_type;

  // decode of the two-bit mode field
  function automatic dtpc_mode_type dtpc_mode(input logic [1:0] f);
    dtpc_mode_type m;
    m = f[1] ? DTPC_CAPTURE : (f[0] ? DTPC_PWM : DTPC_INTERVAL);
    return m;
  endfunction

  // log2 of the divisor for a system-clock select code
  function automatic logic [3:0] dtpc_shift(input logic unit, input logic [2:0] sel);
    logic [4:0] idx;
    idx = {sel, 2'b00};
    return unit ? U1_SHIFT[idx +: 4] : U0_SHIFT[idx +: 4];
  endfunction
endpackage

// file: design/dtpc_unit_if.sv
// Purpose: signals between the register front end and one timer unit
// Assumes: single clock domain
// Notes: host drives control, core and clock select answer
`timescale 1ns/1ns
interface dtpc_unit_if;
  logic [7:0] ctrl;
  logic [7:0] wdata;
  logic       clear_req;
  logic       data_we;
  logic       capture;
  logic       tick;
  logic [7:0] count;
  logic [7:0] data;
  logic [7:0] cmp_buf;
  logic       match_ev;
  logic       ovf_ev;
  logic       toggle;
  logic       pulse;
  modport host (output ctrl, wdata, clear_req, data_we, capture,
                input tick, count, data, cmp_buf, match_ev, ovf_ev, toggle, pulse);
  modport core (input ctrl, wdata, clear_req, data_we, capture, tick,
                output count, data, cmp_buf, match_ev, ovf_ev, toggle, pulse);
  modport clk_sel (input ctrl, output tick);
endinterface

// file: design/dtpc_tick.sv
// Purpose: counting clock source of one unit: prescaler or external edge
// Assumes: external pin already synchronous to clock
// Notes: tick is a one-cycle enable for the counter
`timescale 1ns/1ns
module dtpc_tick #(
  parameter int UNIT = 1
) (
  input  wire logic     clock,
  input  wire logic     sys_rst,
  input  wire logic     ext_pin,
  dtpc_unit_if.clk_sel  u
);
  typedef struct packed {
    logic [dtpc_pkg::PSC_W-1:0] psc;
    logic                       ext_prev;
  } dtpc_tick_state_type;

  dtpc_tick_state_type s_reg, s_next;
  logic [3:0]                 cs;
  logic [dtpc_pkg::PSC_W-1:0] mask;

  if (UNIT < 0 || UNIT > 1)
  begin : g_bad_unit
    $error("UNIT must be 0 or 1");
  end

  // free prescaler and edge history
  always_comb
  begin
    s_next = s_reg;
    s_next.psc = s_reg.psc + {{(dtpc_pkg::PSC_W-1){1'b0}}, 1'b1};
    s_next.ext_prev = ext_pin;
  end

  // select the tick source; unavailable codes give no tick
  always_comb
  begin
    cs = u.ctrl[dtpc_pkg::CS_HI:0];
    mask = ~({dtpc_pkg::PSC_W{1'b1}} << dtpc_shift_w(cs));
    unique case (cs)
      dtpc_pkg::CS_STOP:     u.tick = 1'b0;
      dtpc_pkg::CS_EXT_RISE: u.tick = ext_pin & ~s_reg.ext_prev;
      dtpc_pkg::CS_EXT_FALL: u.tick = ~ext_pin & s_reg.ext_prev;
      default:               u.tick = cs[3] && ((s_reg.psc & mask) == mask);
    endcase
  end

  function automatic logic [3:0] dtpc_shift_w(input logic [3:0] c);
    return dtpc_pkg::dtpc_shift(UNIT[0], c[2:0]);
  endfunction

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
endmodule

// file: design/dtpc_core.sv
// Purpose: counter, compare buffer, data register and outputs of one unit
// Assumes: tick, clear and capture are one-cycle pulses
// Notes: clear beats capture, capture beats a tick in the same cycle
`timescale 1ns/1ns
module dtpc_core (
  input  wire logic  clock,
  input  wire logic  sys_rst,
  dtpc_unit_if.core  u
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cbuf;
    logic [7:0] data;
    logic       tog;
    logic       pwm;
    logic       match_ev;
    logic       ovf_ev;
  } dtpc_core_state_type;

  dtpc_core_state_type    s_reg, s_next;
  dtpc_pkg::dtpc_mode_type mode;
  logic                   hit;

  // counter and event logic
  always_comb
  begin
    s_next = s_reg;
    s_next.match_ev = 1'b0;
    s_next.ovf_ev = 1'b0;
    mode = dtpc_pkg::dtpc_mode(u.ctrl[dtpc_pkg::MODE_HI:dtpc_pkg::MODE_LO]);
    hit = (s_reg.cnt == s_reg.cbuf);
    if (u.data_we)
      s_next.data = u.wdata;
    if (u.clear_req)
    begin
      s_next.cnt = dtpc_pkg::CNT_RST;
      s_next.cbuf = s_reg.data;
    end
    else if (mode == dtpc_pkg::DTPC_CAPTURE && u.capture)
    begin
      s_next.data = s_reg.cnt;
      s_next.cnt = dtpc_pkg::CNT_RST;
    end
    else if (u.tick)
    begin
      s_next.cnt = s_reg.cnt + 8'h01;
      if (mode != dtpc_pkg::DTPC_CAPTURE && hit)
      begin
        s_next.match_ev = 1'b1;
        if (mode == dtpc_pkg::DTPC_INTERVAL)
        begin
          s_next.cnt = dtpc_pkg::CNT_RST;
          s_next.tog = ~s_reg.tog;
        end
      end
      if (s_reg.cnt == dtpc_pkg::CNT_MAX && !(mode == dtpc_pkg::DTPC_INTERVAL && hit))
        s_next.ovf_ev = 1'b1;
      if (s_next.match_ev || s_next.ovf_ev)
        s_next.cbuf = s_next.data;
    end
    // high while the buffer value is above the count, low from the match on
    s_next.pwm = (mode == dtpc_pkg::DTPC_PWM) && (s_next.cbuf > s_next.cnt);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.data <= dtpc_pkg::DATA_RST;
      s_reg.cbuf <= dtpc_pkg::DATA_RST;
    end
    else
      s_reg <= s_next;
  end

  assign u.count = s_reg.cnt;
  assign u.data = s_reg.data;
  assign u.cmp_buf = s_reg.cbuf;
  assign u.match_ev = s_reg.match_ev;
  assign u.ovf_ev = s_reg.ovf_ev;
  assign u.toggle = s_reg.tog;
  assign u.pulse = s_reg.pwm;
endmodule

// file: design/dtpc_top.sv
// Purpose: two 8-bit timers with register port and request flags
// Assumes: pins synchronous to clock; capture pins carry the external
//          interrupt event as a one-cycle pulse
// Notes: read data appear the cycle after the read strobe
`timescale 1ns/1ns
module dtpc_top (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer0_ext_clock_pin,
  input  wire logic       timer1_ext_clock_pin,
  input  wire logic       timer0_capture_pin,
  input  wire logic       timer1_capture_pin,
  input  wire logic [3:0] irq_service_ack,
  output logic            timer0_toggle_out,
  output logic            timer1_toggle_out,
  output logic            timer0_pulse_out,
  output logic            timer1_pulse_out,
  output logic      [3:0] irq_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [3:0] irq_req;
    logic [3:0] irq_en;
    logic [3:0] irq_out;
    logic [7:0] rdata;
  } dtpc_top_state_type;

  dtpc_top_state_type s_reg, s_next;
  logic [3:0]         events;
  logic [3:0]         sw_clear;
  logic               wr_ctrl0;
  logic               wr_ctrl1;

  dtpc_unit_if u0 ();
  dtpc_unit_if u1 ();

  // ------------------------------------------------------------
  // timer units
  // ------------------------------------------------------------
  dtpc_tick #(.UNIT(0)) tick0 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ext_pin (timer0_ext_clock_pin),
    .u       (u0.clk_sel)
  );

  dtpc_tick #(.UNIT(1)) tick1 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ext_pin (timer1_ext_clock_pin),
    .u       (u1.clk_sel)
  );

  dtpc_core core0 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .u       (u0.core)
  );

  dtpc_core core1 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .u       (u1.core)
  );

  // ------------------------------------------------------------
  // register decode toward the units
  // ------------------------------------------------------------
  // write strobes, clear pulses and capture events
  assign wr_ctrl0 = reg_wr && (reg_addr == dtpc_pkg::ADDR_T0_CTRL);
  assign wr_ctrl1 = reg_wr && (reg_addr == dtpc_pkg::ADDR_T1_CTRL);
  assign u0.ctrl = s_reg.ctrl0;
  assign u1.ctrl = s_reg.ctrl1;
  assign u0.wdata = reg_wdata;
  assign u1.wdata = reg_wdata;
  assign u0.clear_req = wr_ctrl0 && reg_wdata[dtpc_pkg::CLR_BIT];
  assign u1.clear_req = wr_ctrl1 && reg_wdata[dtpc_pkg::CLR_BIT];
  assign u0.data_we = reg_wr && (reg_addr == dtpc_pkg::ADDR_T0_DATA);
  assign u1.data_we = reg_wr && (reg_addr == dtpc_pkg::ADDR_T1_DATA);
  assign u0.capture = timer0_capture_pin;
  assign u1.capture = timer1_capture_pin;

  // ------------------------------------------------------------
  // control, request flags and read port
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    events = '0;
    events[dtpc_pkg::IRQ_T0_MATCH] = u0.match_ev;
    events[dtpc_pkg::IRQ_T0_OVF] = u0.ovf_ev;
    events[dtpc_pkg::IRQ_T1_MATCH] = u1.match_ev;
    events[dtpc_pkg::IRQ_T1_OVF] = u1.ovf_ev;
    sw_clear = '0;
    // clear bit never stores
    if (wr_ctrl0)
    begin
      s_next.ctrl0 = reg_wdata;
      s_next.ctrl0[dtpc_pkg::CLR_BIT] = 1'b0;
    end
    if (wr_ctrl1)
    begin
      s_next.ctrl1 = reg_wdata;
      s_next.ctrl1[dtpc_pkg::CLR_BIT] = 1'b0;
    end
    if (reg_wr && reg_addr == dtpc_pkg::ADDR_IRQ_EN)
      s_next.irq_en = reg_wdata[7:dtpc_pkg::IRQ_LSB];
    if (reg_wr && reg_addr == dtpc_pkg::ADDR_IRQ_REQ)
      sw_clear = ~reg_wdata[7:dtpc_pkg::IRQ_LSB];
    // service or software clears, a new event wins
    s_next.irq_req = (s_reg.irq_req & ~irq_service_ack & ~sw_clear) | events;
    s_next.irq_out = s_next.irq_req & s_next.irq_en;
    // read mux, unmapped reads zero
    s_next.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        dtpc_pkg::ADDR_T0_CTRL: s_next.rdata = s_reg.ctrl0;
        dtpc_pkg::ADDR_T0_DATA: s_next.rdata = u0.data;
        dtpc_pkg::ADDR_T0_CNT:  s_next.rdata = u0.count;
        dtpc_pkg::ADDR_T1_CTRL: s_next.rdata = s_reg.ctrl1;
        dtpc_pkg::ADDR_T1_DATA: s_next.rdata = u1.data;
        dtpc_pkg::ADDR_T1_CNT:  s_next.rdata = u1.count;
        dtpc_pkg::ADDR_IRQ_REQ: s_next.rdata = {s_reg.irq_req, 4'h0};
        dtpc_pkg::ADDR_IRQ_EN:  s_next.rdata = {s_reg.irq_en, 4'h0};
        default:                s_next.rdata = 8'h00;
      endcase
    end
  end

  // register the state
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.ctrl0 <= dtpc_pkg::CTRL_RST;
      s_reg.ctrl1 <= dtpc_pkg::CTRL_RST;
      s_reg.irq_req <= dtpc_pkg::IRQ_RST;
      s_reg.irq_en <= dtpc_pkg::IRQ_RST;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from flops
  assign reg_rdata = s_reg.rdata;
  assign irq_out = s_reg.irq_out;
  assign timer0_toggle_out = u0.toggle;
  assign timer1_toggle_out = u1.toggle;
  assign timer0_pulse_out = u0.pulse;
  assign timer1_pulse_out = u1.pulse;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // step of an interval match on unit 1
  sequence int_hit_s;
    u1.ctrl[6:5] == 2'b00 && u1.tick && u1.count == u1.cmp_buf && !u1.clear_req;
  endsequence

  sequence int_after_s;
    u1.count == dtpc_pkg::CNT_RST && u1.match_ev && u1.toggle != $past(u1.toggle);
  endsequence

  // wrap in capture mode, then the flag
  sequence cap_wrap_s;
    u1.ctrl[6] && u1.tick && u1.count == dtpc_pkg::CNT_MAX && !u1.capture && !u1.clear_req;
  endsequence

  sequence ovf_flag_s;
    u1.ovf_ev ##1 s_reg.irq_req[dtpc_pkg::IRQ_T1_OVF];
  endsequence

  property int_match_p;
    int_hit_s |=> int_after_s;
  endproperty

  property cap_ovf_p;
    cap_wrap_s |=> ovf_flag_s;
  endproperty

  cap_no_match_a: assert property ($past(u1.ctrl[6]) |-> !u1.match_ev)
    else $error("match event in capture mode");

  stop_hold_a: assert property (
    (u1.ctrl[3:0] == dtpc_pkg::CS_STOP && !u1.clear_req && !u1.capture) |=> $stable(u1.count))
    else $error("stopped counter moved");

  div_one_a: assert property ((u1.ctrl[3:0] == dtpc_pkg::CS_DIV_FIRST) |-> u1.tick)
    else $error("unit 1 divide by one missed a tick");

  div_two_a: assert property (
    (u0.ctrl[3:0] == dtpc_pkg::CS_DIV_FIRST && $past(u0.ctrl[3:0]) == dtpc_pkg::CS_DIV_FIRST)
      |-> u0.tick != $past(u0.tick))
    else $error("unit 0 divide by two not alternating");

  clear_cnt_a: assert property (
    u1.clear_req |=> u1.count == dtpc_pkg::CNT_RST && !s_reg.ctrl1[dtpc_pkg::CLR_BIT])
    else $error("clear bit did not clear counter");

  clear_load_a: assert property (u1.clear_req |=> u1.cmp_buf == $past(u1.data))
    else $error("buffer not loaded on clear");

  event_load_a: assert property ((u0.match_ev || u0.ovf_ev) |-> u0.cmp_buf == u0.data)
    else $error("unit 0 buffer not loaded on event");

  int_match_a: assert property (int_match_p)
    else $error("interval match did not clear and toggle");

  pwm_free_a: assert property (
    (u1.ctrl[6:5] == 2'b01 && u1.tick && !u1.clear_req) |=> u1.count == $past(u1.count) + 8'h01)
    else $error("PWM counter did not run freely");

  pwm_level_a: assert property (
    $past(u1.ctrl[6:5]) == 2'b01 |-> u1.pulse == (u1.cmp_buf > u1.count))
    else $error("PWM level wrong");

  capture_a: assert property (
    (u1.ctrl[6] && u1.capture && !u1.clear_req)
      |=> u1.count == dtpc_pkg::CNT_RST && u1.data == $past(u1.count))
    else $error("capture did not copy counter");

  cap_ovf_a: assert property (cap_ovf_p)
    else $error("capture overflow not requested");

  irq_gate_a: assert property ((s_reg.irq_out & ~s_reg.irq_en) == 4'h0)
    else $error("request delivered while disabled");

  set_wins_a: assert property (u1.match_ev |=> s_reg.irq_req[dtpc_pkg::IRQ_T1_MATCH])
    else $error("match event lost");

  ack_clear_a: assert property (
    (irq_service_ack[dtpc_pkg::IRQ_T1_OVF] && !u1.ovf_ev) |=> !s_reg.irq_req[dtpc_pkg::IRQ_T1_OVF])
    else $error("overflow flag not cleared on service");

  ack0_clear_a: assert property (
    (irq_service_ack[dtpc_pkg::IRQ_T0_MATCH] && !u0.match_ev)
      |=> !s_reg.irq_req[dtpc_pkg::IRQ_T0_MATCH])
    else $error("unit 0 match flag not cleared on service");
endmodule

// file: tb/dtpc_pins.sv
// Purpose: far-side pins of the timer block: external clocks and capture events
// Assumes: pins are driven just after a rising clock edge
// Notes: external clocks stand still at 0 outside a burst of pulses
`timescale 1ns/1ns
module dtpc_pins (
  input  wire logic clock,
  output logic      timer0_ext_clock_pin,
  output logic      timer1_ext_clock_pin,
  output logic      timer0_capture_pin,
  output logic      timer1_capture_pin
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial
  begin
    timer0_ext_clock_pin = 1'b0;
    timer1_ext_clock_pin = 1'b0;
    timer0_capture_pin   = 1'b0;
    timer1_capture_pin   = 1'b0;
  end

  // n full pulses, two cycles high and two low, pin back at 0 afterwards
  task automatic ext_edges(input int unit, input int n);
    for (int i = 0; i < 2 * n; i++)
    begin
      @(posedge clock);
      if (unit == 0)
        timer0_ext_clock_pin <= ~timer0_ext_clock_pin;
      else
        timer1_ext_clock_pin <= ~timer1_ext_clock_pin;
      @(posedge clock);
    end
  endtask

  // one-cycle external interrupt event on a capture pin
  task automatic capture(input int unit);
    @(posedge clock);
    if (unit == 0)
      timer0_capture_pin <= 1'b1;
    else
      timer1_capture_pin <= 1'b1;
    @(posedge clock);
    timer0_capture_pin <= 1'b0;
    timer1_capture_pin <= 1'b0;
  endtask
endmodule

// file: tb/dtpc_top_tb.sv
// Purpose: self-checking bench of the dual 8-bit timer block
// Assumes: register port with read data one cycle after the strobe
// Notes: software writes data before control in the interval, buffer and PWM scenarios
`timescale 1ns/1ns
module dtpc_top_tb;
  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       ec0;
  logic       ec1;
  logic       cap0;
  logic       cap1;
  logic [3:0] irq_service_ack;
  logic       tog0;
  logic       tog1;
  logic       pwm0;
  logic       pwm1;
  logic [3:0] irq_out;
  int         n_fail;
  int         compares;
  int         n;
  int         d;
  int         d2;
  int         hi;
  logic [7:0] v;
  logic [7:0] v2;
  int         seed;

  dtpc_top dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_ext_clock_pin(ec0),
    .timer1_ext_clock_pin(ec1), .timer0_capture_pin(cap0), .timer1_capture_pin(cap1),
    .irq_service_ack(irq_service_ack), .timer0_toggle_out(tog0), .timer1_toggle_out(tog1),
    .timer0_pulse_out(pwm0), .timer1_pulse_out(pwm1), .irq_out(irq_out));

  dtpc_pins partner (.clock(clock), .timer0_ext_clock_pin(ec0), .timer1_ext_clock_pin(ec1),
    .timer0_capture_pin(cap0), .timer1_capture_pin(cap1));

  // ----------------------------------------
  // clock, 50 ns period
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  task automatic ack(input int b);
    @(posedge clock);
    irq_service_ack <= 4'h1 << b;
    @(posedge clock);
    irq_service_ack <= 4'h0;
    #1;
  endtask

  // cycles until the toggle output of a unit changes
  task automatic wait_flip(input int u, output int c);
    logic t;
    t = u ? tog1 : tog0;
    c = 0;
    while ((u ? tog1 : tog0) === t)
    begin
      @(posedge clock);
      #1;
      c++;
      if (c > 5000)
      begin
        n_fail++;
        end_of_test();
      end
    end
  endtask

  // system clock divisor of select code 8+k
  function automatic int div(input int u, input int k);
    int s;
    s = (k < 5) ? k : 2 * k - 4;
    return (u == 1) ? (1 << s) : (2 << s);
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    irq_service_ack = 4'h0;
    seed = $urandom(32'hEB6D);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rd(8'hB3, v); chk("ctrl1 reset", 8'h00, v);
    rd(8'hB4, v); chk("data1 reset", 8'hFF, v);
    rd(8'hB5, v); chk("count1 reset", 8'h00, v);
    wr(8'hB9, 8'h5A);
    rd(8'hB9, v); chk("unmapped", 8'h00, v);
    wr(8'hBB, 8'hF0);
    // interval mode on both units, two divisors each
    for (int u = 0; u < 2; u++)
      for (int k = 0; k < 2; k++)
      begin
        d = 4 + $urandom_range(5);
        wr(u ? 8'hB4 : 8'hB1, d[7:0]);
        wr(u ? 8'hB3 : 8'hB0, {4'h1, 1'b1, k[2:0]});
        wait_flip(u, n);
        wait_flip(u, n);
        chk("interval period", div(u, k) * (d + 1), n);
        wr(u ? 8'hB3 : 8'hB0, 8'h00);
        chk("match request", 1'b1, irq_out[u ? 1 : 3]);
        wr(8'hBB, 8'h00);
        chk("masked request", 1'b0, irq_out[u ? 1 : 3]);
        wr(8'hBB, 8'hF0);
        chk("unmasked request", 1'b1, irq_out[u ? 1 : 3]);
        ack(u ? 1 : 3);
        chk("serviced request", 1'b0, irq_out[u ? 1 : 3]);
      end
    // counter holds while stopped, clear bit clears it and reads back 0
    rd(8'hB2, v);
    repeat (5) @(posedge clock);
    rd(8'hB2, v2); chk("stopped count", v, v2);
    wr(8'hB0, 8'h90);
    rd(8'hB2, v); chk("cleared count", 8'h00, v);
    rd(8'hB0, v); chk("clear bit", 8'h80, v);
    // new compare value waits in the data register until the next match loads the buffer
    d = 5;
    d2 = 3 + $urandom_range(6);
    wr(8'hB4, d[7:0]);
    wr(8'hB3, 8'h18);
    wait_flip(1, n);
    wr(8'hB4, d2[7:0]);
    wait_flip(1, n); chk("old buffer period", d + 1, n + 2);
    wait_flip(1, n); chk("reloaded period", d2 + 1, n);
    // PWM duty over one 256-tick period, a zero compare among them
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 1 + $urandom_range(199) : 0;
      wr(8'hB4, d[7:0]);
      wr(8'hB3, 8'h38);
      repeat (300) @(posedge clock);
      #1;
      hi = 0;
      for (int c = 0; c < 256; c++)
      begin
        hi += (pwm1 === 1'b1);
        @(posedge clock);
        #1;
      end
      chk("pwm high time", d, hi);
      chk("pwm overflow request", 1'b1, irq_out[0]);
      chk("pwm match request", 1'b1, irq_out[1]);
      wr(8'hB3, 8'h20);
      ack(0);
      ack(1);
      chk("serviced overflow", 1'b0, irq_out[0]);
    end
    chk("pulse low outside pwm", 1'b0, pwm0);
    // capture of external edge counts, rising then falling
    for (int k = 5; k < 7; k++)
    begin
      d = 3 + $urandom_range(10);
      wr(8'hB3, {(k == 6) ? 4'h7 : 4'h5, k[3:0]});
      partner.ext_edges(1, d);
      partner.capture(1);
      rd(8'hB4, v); chk("captured count", d[7:0], v);
      rd(8'hB5, v); chk("count after capture", 8'h00, v);
      chk("no match in capture", 1'b0, irq_out[1]);
    end
    end_of_test();
  end
endmodule
